//--- include/rmvs_cfg.svh
// Register offsets, field positions, reset values and widths for the regulator selector
`ifndef RMVS_CFG_SVH
`define RMVS_CFG_SVH

// Avalon byte address width and data width
`define RMVS_ADDR_W        8
`define RMVS_DATA_W        32

// Register byte offsets
`define RMVS_OFF_ASSIGN0   8'h00
`define RMVS_OFF_ASSIGN1   8'h04
`define RMVS_OFF_ASSIGN2   8'h08
`define RMVS_OFF_ASSIGN3   8'h0C
`define RMVS_OFF_VSEL      8'h10
`define RMVS_OFF_LOWSTATE  8'h14
`define RMVS_OFF_DEVCTL2   8'h18
`define RMVS_OFF_LDOMAP    8'h1C
`define RMVS_OFF_STATUS0   8'h20
`define RMVS_OFF_STATUS1   8'h24

// Field positions
`define RMVS_VSEL_VOLTAGE_REG_SELECT_BIT_LSB   0
`define RMVS_VSEL_LOWV_LSB     8
`define RMVS_LOW_KEEP_LSB      0
`define RMVS_LOW_OFF_LSB       8
`define RMVS_DEV_SLEEP_EN_BIT  0
`define RMVS_DEV_SLEEP_PIN_POLARITY_BIT_BIT 1
`define RMVS_ST0_ALT_LSB       0
`define RMVS_ST0_COND_LSB      8
`define RMVS_ST0_STATE_LSB     16

// Reset values
`define RMVS_RST_ASSIGN    8'h00
`define RMVS_RST_VSEL      16'h0000
`define RMVS_RST_LOWSTATE  16'h0000
`define RMVS_RST_DEVCTL2   2'h0
`define RMVS_RST_LDOMAP    8'hE4

`endif

//--- include/rmvs_pkg.sv
// Types shared by the regulator mode and voltage selector
package rmvs_pkg;

  // Device operating state seen by the selector
  typedef enum logic [1:0] {
    RMVS_ST_OTHER,
    RMVS_ST_ACTIVE,
    RMVS_ST_SLEEP
  } rmvs_state_t;

  // Resulting resource mode
  typedef enum logic [1:0] {
    RMVS_MODE_OFF,
    RMVS_MODE_ECO,
    RMVS_MODE_ON
  } rmvs_mode_t;

  // Sleep pin control fields of the second device control register
  typedef struct packed {
    logic sleep_pin_polarity_bit;
    logic sleep_en;
  } rmvs_devctl_t;

  // Per-resource low-state settings
  typedef struct packed {
    logic [7:0] off_bits;
    logic [7:0] keep_bits;
  } rmvs_lowstate_t;

endpackage : rmvs_pkg

//--- verification/rmvs_host_model.sv
// Host processor model driving the strap, enable, request and sleep pins
`timescale 1ns/1ps
`default_nettype none

module rmvs_host_model (
  input  wire logic       clk_in,       // Device clock
  input  wire logic       reset_in,     // Board reset, active high
  input  wire logic       strap_cmd_in, // Strap level chosen for the board
  input  wire logic [3:0] en_cmd_in,    // Wanted enable or select levels
  input  wire logic [2:0] req_cmd_in,   // Wanted request levels
  input  wire logic       sleep_cmd_in, // Wanted sleep level
  output logic            strap_out,    // Strap pin
  output logic      [3:0] en_out,       // Enable or select pins
  output logic      [2:0] req_out,      // Power and clock request pins
  output logic            sleep_out     // Sleep pin
);
  // strap hardwired, set only in reset
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      strap_out <= strap_cmd_in;
    end
  end

  always_ff @(posedge clk_in) begin
    en_out    <= en_cmd_in;
    req_out   <= req_cmd_in;
    sleep_out <= sleep_cmd_in;
  end
endmodule // rmvs_host_model

`default_nettype wire

//--- verification/rmvs_top_test.sv
// Self-checking bench for the regulator mode and voltage selector
`timescale 1ns/1ps
`include "rmvs_cfg.svh"
`default_nettype none

module rmvs_top_test;
  logic        ref_clk_in, reset_in, operating, irq, otp_load, strap_c, sleep_c;
  logic        strap_w, sleep_w, rd, wr, wait_w;
  logic [3:0]  en_c, en_w;
  logic [2:0]  req_c, req_w;
  logic [7:0]  addr, alt_w, vsel_s, lowv_s, keep_s, off_s, map_s;
  logic [31:0] otp_val, wdata, rdata, rd_w;
  logic [15:0] mode_w;
  logic [1:0]  st_w, dev_s;
  logic [7:0]  sets [4];
  int          miscompares, tests_run;

  rmvs_host_model rmvs_host_model_inst (.clk_in(ref_clk_in), .reset_in(reset_in),
    .strap_cmd_in(strap_c), .en_cmd_in(en_c), .req_cmd_in(req_c), .sleep_cmd_in(sleep_c),
    .strap_out(strap_w), .en_out(en_w), .req_out(req_w), .sleep_out(sleep_w));

  rmvs_top rmvs_top_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .pin_map_strap_in(strap_w), .resource_enable_pin_in(en_w),
    .power_request_pin_in(req_w[0]), .clock_request_first_pin_in(req_w[1]),
    .clock_request_second_pin_in(req_w[2]), .sleep_pin_in(sleep_w),
    .operating_in(operating), .irq_pending_in(irq), .otp_load_in(otp_load),
    .otp_assign_in(otp_val), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rd_w), .avs_waitrequest(wait_w),
    .resource_mode_out(mode_w), .alt_select_out(alt_w), .device_state_out(st_w));

  // Clock at 50 MHz
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  task automatic end_sim();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wait_w !== 1'b0 && n < 20);
    rdata = rd_w;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 20) begin
      $display("ERROR bus answer timeout");
      miscompares++;
      end_sim();
    end
    if (w) begin
      case (a)
        `RMVS_OFF_ASSIGN0:  sets[0] = d[7:0];
        `RMVS_OFF_ASSIGN1:  sets[1] = d[7:0];
        `RMVS_OFF_ASSIGN2:  sets[2] = d[7:0];
        `RMVS_OFF_ASSIGN3:  sets[3] = d[7:0];
        `RMVS_OFF_VSEL:     {lowv_s, vsel_s} = d[15:0];
        `RMVS_OFF_LOWSTATE: {off_s, keep_s} = d[15:0];
        `RMVS_OFF_DEVCTL2:  dev_s = d[1:0];
        `RMVS_OFF_LDOMAP:   map_s = d[7:0];
        default: ;
      endcase
    end
  endtask

  // Expected outputs from pin levels and register shadows
  task automatic check_all();
    logic [7:0] ea;
    logic [15:0] em;
    logic [1:0] es;
    logic asg, cnd, lo, slp;
    repeat (8) @(posedge ref_clk_in);
    slp = strap_c & operating & dev_s[0] & !irq & (sleep_c == dev_s[1]);
    es = !operating ? 2'h0 : (slp ? 2'h2 : 2'h1);
    for (int i = 0; i < 8; i++) begin
      asg = 1'b0;
      cnd = 1'b0;
      for (int p = 0; p < 4; p++) begin
        if (strap_c || p < 3) begin
          asg = asg | sets[p][i];
          cnd = cnd | (sets[p][i] & (strap_c ? en_c[p] : req_c[p % 3]));
        end
      end
      lo = !operating | (asg ? !cnd : slp);
      em[2*i +: 2] = !operating ? rmvs_pkg::RMVS_MODE_OFF : (!lo | keep_s[i]) ?
        rmvs_pkg::RMVS_MODE_ON : off_s[i] ? rmvs_pkg::RMVS_MODE_OFF : rmvs_pkg::RMVS_MODE_ECO;
      ea[i] = strap_c ? (vsel_s[i] | (lo & lowv_s[i])) : en_c[(i < 4) ? i : map_s[2*(i%4) +: 2]];
    end
    check("alt_select", 32'(alt_w), 32'(ea));
    check("resource_mode", 32'(mode_w), 32'(em));
    check("device_state", 32'(st_w), 32'(es));
  endtask

  task automatic do_reset(input logic strap);
    strap_c <= strap;
    reset_in <= 1'b1;
    repeat (12) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    sets = '{default: 8'h00};
    {vsel_s, lowv_s, keep_s, off_s} = 32'h0;
    dev_s = 2'h0;
    map_s = `RMVS_RST_LDOMAP;
  endtask

  // Reset values, then an unmapped write and read
  task automatic t_reset_vals();
    logic [7:0] offs [8] = '{`RMVS_OFF_ASSIGN0, `RMVS_OFF_ASSIGN1, `RMVS_OFF_ASSIGN2,
      `RMVS_OFF_ASSIGN3, `RMVS_OFF_VSEL, `RMVS_OFF_LOWSTATE, `RMVS_OFF_DEVCTL2, 8'h40};
    for (int k = 0; k < 8; k++) begin
      bus(1'b0, offs[k], 32'h0);
      check("reset_value", rdata, 32'h0);
    end
    bus(1'b0, `RMVS_OFF_LDOMAP, 32'h0);
    check("ldo_map_reset", rdata, 32'(`RMVS_RST_LDOMAP));
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped_read", rdata, 32'h0);
  endtask

  // Strap low: select pins pick voltage, request pins switch sets
  task automatic t_strap_low();
    bus(1'b1, `RMVS_OFF_LDOMAP, 32'h0000001B);
    bus(1'b1, `RMVS_OFF_VSEL, 32'h0000FFFF);
    bus(1'b1, `RMVS_OFF_LOWSTATE, 32'h00000700);
    bus(1'b1, `RMVS_OFF_DEVCTL2, 32'h00000001);
    bus(1'b1, `RMVS_OFF_ASSIGN0, 32'h00000001);
    bus(1'b1, `RMVS_OFF_ASSIGN1, 32'h00000002);
    bus(1'b1, `RMVS_OFF_ASSIGN2, 32'h00000004);
    bus(1'b1, `RMVS_OFF_ASSIGN3, 32'h00000000);
    for (int k = 0; k < 16; k++) begin
      en_c <= 4'(k);
      req_c <= 3'(k ^ 5);
      check_all();
    end
  endtask

  // OTP copy into the sets, then a software rewrite
  task automatic t_otp_load();
    otp_val <= 32'h80041311;
    otp_load <= 1'b1;
    @(posedge ref_clk_in);
    otp_load <= 1'b0;
    sets = '{8'h11, 8'h13, 8'h04, 8'h80};
    for (int p = 0; p < 4; p++) begin
      bus(1'b0, `RMVS_OFF_ASSIGN0 + 8'(4 * p), 32'h0);
      check("otp_set", rdata, 32'(sets[p]));
    end
    bus(1'b1, `RMVS_OFF_ASSIGN3, 32'h00000008);
    bus(1'b0, `RMVS_OFF_ASSIGN3, 32'h0);
    check("set_rewrite", rdata, 32'h00000008);
  endtask

  // Every enable pin pattern with sleep toggling beside it
  task automatic t_enable_or();
    bus(1'b1, `RMVS_OFF_LOWSTATE, 32'h00004221);
    bus(1'b1, `RMVS_OFF_VSEL, 32'h0000F003);
    bus(1'b1, `RMVS_OFF_DEVCTL2, 32'h00000001);
    for (int k = 0; k < 32; k++) begin
      en_c <= 4'(k);
      sleep_c <= 1'(k >> 4);
      check_all();
    end
  endtask

  // Sleep gate, polarity and pending interrupt, then state other
  task automatic t_sleep();
    en_c <= 4'h0;
    for (int k = 0; k < 16; k++) begin
      bus(1'b1, `RMVS_OFF_DEVCTL2, 32'(k & 3));
      irq <= 1'(k >> 2);
      sleep_c <= 1'(k >> 3);
      check_all();
    end
    operating <= 1'b0;
    en_c <= 4'hF;
    check_all();
  endtask

  // Main sequence
  initial begin
    {reset_in, operating} = 2'b11;
    {irq, otp_load, strap_c, sleep_c, rd, wr} = 6'h00;
    {en_c, req_c, addr, otp_val, wdata} = 79'h0;
    miscompares = 0;
    tests_run = 0;
    do_reset(1'b0);
    t_reset_vals();
    t_strap_low();
    do_reset(1'b1);
    t_otp_load();
    t_enable_or();
    t_sleep();
    end_sim();
  end
endmodule // rmvs_top_test

`default_nettype wire

//--- verilog/rmvs_top.sv
// Regulator mode and voltage register selector with Avalon-MM registers
//
// Behaviour
// (R1) Bucks get primary and alternate voltage registers
// (R2) First four LDOs select voltage the same
// (R3) Strap low: select pin picks voltage register
// (R4) Strap high, level high: select bit decides
// (R5) Level low, select bit 0: low-state voltage bit
// (R6) Assigned enable condition is OR of pins
// (R7) Many-to-many pin to resource assignment allowed
// (R8) OTP loads assignments; software may rewrite
// (R9) Enable pins count only in ACTIVE/SLEEP
// (R10) Sleep pin needs gate bit, no interrupt
// (R11) Sleep pin polarity from control register
// (R12) SLEEP governs resources by low-state bits
// (R13) Unassigned, keep bit set: stays on
// (R14) Unassigned, keep and off clear: eco
// (R15) Unassigned, off set, keep clear: off
// (R16) Assigned resources ignore device sleep state
// (R17) Assigned, condition high: resource enabled
// (R18) Assigned, condition low: keep/off/eco bits
// (R19) Strap low: request pins use sets one-three
// (R20) Software zeroes fourth set when strap low
// (R21) LDO select pin chosen by mapping register
// (R22) Strap is hardwired, never switched live
// (R23) All pin inputs synchronised before use
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "rmvs_cfg.svh"
`default_nettype none

module rmvs_top #(
  parameter int NUM_BUCK = 4,                        // Buck converters
  parameter int NUM_LDO  = 4,                        // Linear regulators with two registers
  parameter int NUM_PIN  = 4                         // Enable pins
) (
  input  wire logic                      ref_clk_in,          // 50 MHz clock
  input  wire logic                      reset_in,            // Async reset, active high
  input  wire logic                      pin_map_strap_in,    // Pin-map strap pin
  input  wire logic [3:0]                resource_enable_pin_in, // Enable or select pins
  input  wire logic                      power_request_pin_in,   // Request pin, set one
  input  wire logic                      clock_request_first_pin_in,  // Request pin, set two
  input  wire logic                      clock_request_second_pin_in, // Request pin, set three
  input  wire logic                      sleep_pin_in,        // Sleep pin
  input  wire logic                      operating_in,        // Device in ACTIVE/SLEEP range
  input  wire logic                      irq_pending_in,      // Unmasked interrupt pending
  input  wire logic                      otp_load_in,         // One-cycle OTP copy strobe
  input  wire logic [31:0]               otp_assign_in,       // OTP assignment sets, 8 bits each
  input  wire logic [`RMVS_ADDR_W-1:0]   avs_address,         // Byte address
  input  wire logic                      avs_read,            // Read request
  input  wire logic                      avs_write,           // Write request
  input  wire logic [`RMVS_DATA_W-1:0]   avs_writedata,       // Write data
  output logic      [`RMVS_DATA_W-1:0]   avs_readdata,        // Read data
  output logic                           avs_waitrequest,     // Stall, high when idle
  output logic      [15:0]               resource_mode_out,   // 2-bit mode per resource
  output logic      [7:0]                alt_select_out,      // 1: alternate register
  output logic      [1:0]                device_state_out     // Current device state
);

  localparam int NRES = 8;

  // Register layout fixes the resource and pin counts
  if (NUM_BUCK != 4 || NUM_LDO != 4 || NUM_PIN != 4) begin : g_bad_cfg
    $error("rmvs_top: register layout serves exactly 4 bucks, 4 LDOs, 4 pins");
  end

  // Low-state decision for one resource
  function automatic rmvs_pkg::rmvs_mode_t low_mode(input logic hi, input logic keep,
                                                    input logic off);
    if (hi || keep) begin
      return rmvs_pkg::RMVS_MODE_ON;
    end else if (off) begin
      return rmvs_pkg::RMVS_MODE_OFF;
    end
    return rmvs_pkg::RMVS_MODE_ECO;
  endfunction

  // Synchroniser stages: en[3:0], req[6:4], sleep[7], strap[8]
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  wire  [8:0] pins_raw = {pin_map_strap_in, sleep_pin_in, clock_request_second_pin_in,
                          clock_request_first_pin_in, power_request_pin_in,
                          resource_enable_pin_in};

  // R23 two-stage sync
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_reg <= 9'h000;
      sync2_reg <= 9'h000;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  wire [3:0] en_s    = sync2_reg[3:0];
  wire [2:0] req_s   = sync2_reg[6:4];
  wire       sleep_s = sync2_reg[7];
  // R22 strap read as static level
  wire       strap_s = sync2_reg[8];

  // Software registers
  logic [7:0]              assign_reg [4];
  logic [15:0]             vsel_reg;
  rmvs_pkg::rmvs_lowstate_t low_reg;
  rmvs_pkg::rmvs_devctl_t  devctl_reg;
  logic [7:0]              ldomap_reg;
  rmvs_pkg::rmvs_state_t   state_reg;
  logic [15:0]             mode_reg;
  logic [7:0]              alt_reg;
  logic [7:0]              cond_reg;
  logic [`RMVS_DATA_W-1:0] rdata_reg;
  logic                    wait_reg;

  // Bus decode
  wire       bus_req   = avs_read | avs_write;
  wire       bus_take  = bus_req & ~wait_reg;
  wire       wr_take   = avs_write & ~wait_reg;
  wire [7:0] addr      = avs_address;
  wire       hit_vsel  = addr == `RMVS_OFF_VSEL;
  wire       hit_low   = addr == `RMVS_OFF_LOWSTATE;
  wire       hit_dev   = addr == `RMVS_OFF_DEVCTL2;
  wire       hit_map   = addr == `RMVS_OFF_LDOMAP;
  wire [1:0] asg_idx   = addr[3:2];
  wire       hit_asg   = addr[7:4] == 4'h0 && addr[1:0] == 2'h0;

  // Bus handshake: one wait cycle then release
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~(bus_req & wait_reg);
    end
  end

  // R8 assignment sets: OTP copy wins, else software
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int p = 0; p < 4; p++) begin
        assign_reg[p] <= `RMVS_RST_ASSIGN;
      end
    end else if (otp_load_in) begin
      for (int p = 0; p < 4; p++) begin
        assign_reg[p] <= otp_assign_in[p*8 +: 8];
      end
    end else if (wr_take && hit_asg) begin
      assign_reg[asg_idx] <= avs_writedata[7:0];
    end
  end

  // Control registers
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      vsel_reg   <= `RMVS_RST_VSEL;
      low_reg    <= `RMVS_RST_LOWSTATE;
      devctl_reg <= `RMVS_RST_DEVCTL2;
      ldomap_reg <= `RMVS_RST_LDOMAP;
    end else if (wr_take) begin
      if (hit_vsel) vsel_reg <= avs_writedata[15:0];
      if (hit_low) low_reg <= avs_writedata[15:0];
      if (hit_dev) devctl_reg <= avs_writedata[1:0];
      if (hit_map) ldomap_reg <= avs_writedata[7:0];
    end
  end

  wire [7:0] voltage_reg_select_bit_b = vsel_reg[`RMVS_VSEL_VOLTAGE_REG_SELECT_BIT_LSB +: 8];
  wire [7:0] lowv_b   = vsel_reg[`RMVS_VSEL_LOWV_LSB +: 8];

  // R11 polarity: 1 means sleep pin high requests sleep
  wire sleep_lvl = devctl_reg.sleep_pin_polarity_bit ? sleep_s : ~sleep_s;
  // R10 gate and interrupt qualification
  wire sleep_req = devctl_reg.sleep_en & ~irq_pending_in & sleep_lvl;

  // Device state; sleep pin is remapped away when strap is low
  wire rmvs_pkg::rmvs_state_t state_next =
      !operating_in          ? rmvs_pkg::RMVS_ST_OTHER :
      (strap_s && sleep_req) ? rmvs_pkg::RMVS_ST_SLEEP : rmvs_pkg::RMVS_ST_ACTIVE;

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= rmvs_pkg::RMVS_ST_OTHER;
    end else begin
      state_reg <= state_next;
    end
  end

  // R9 pins only act in ACTIVE or SLEEP
  wire pins_live = state_reg != rmvs_pkg::RMVS_ST_OTHER;
  // R19 strap low: request pins on sets one to three
  // R20 fourth set disregarded when strap low
  wire [3:0] ctl_pins = strap_s ? en_s : {1'b0, req_s};
  wire [3:0] set_use  = strap_s ? 4'hF : 4'h7;

  // Per-resource decision wires
  wire [7:0]               assigned;
  wire [7:0]               cond;
  wire [7:0]               use_pins;
  wire [7:0]               level_hi;
  wire [7:0]               vsel_pin;
  wire [7:0]               alt_next;
  rmvs_pkg::rmvs_mode_t    mode_next [NRES];

  for (genvar i = 0; i < NRES; i++) begin : g_res
    wire [3:0] col = {assign_reg[3][i], assign_reg[2][i], assign_reg[1][i], assign_reg[0][i]};
    // R7 any pin to any resource
    assign assigned[i] = |(col & set_use);
    // R6 OR of all assigned pins
    assign cond[i]     = |(col & set_use & ctl_pins);
    assign use_pins[i] = assigned[i] & pins_live;
    // R16 assigned follows pins, else device state
    assign level_hi[i] = use_pins[i] ? cond[i] : (state_reg == rmvs_pkg::RMVS_ST_ACTIVE);
    if (i < NUM_BUCK) begin : g_buck
      // R1 buck select pin is its own pin
      assign vsel_pin[i] = en_s[i];
    end else begin : g_ldo
      // R21 LDO select pin from mapping register
      assign vsel_pin[i] = en_s[ldomap_reg[(i-NUM_BUCK)*2 +: 2]];
    end
    // R2 same voltage choice for LDOs
    // R3 strap low: pin picks register
    // R4 level high: select bit; select bit 1 always alternate
    // R5 level low: low-state voltage bit
    assign alt_next[i] = !strap_s ? vsel_pin[i] :
                         (voltage_reg_select_bit_b[i] | (~level_hi[i] & lowv_b[i]));
    // R12 SLEEP and pin-low use low-state bits
    // R13 keep bit keeps on
    // R14 both clear gives eco
    // R15 off bit turns off
    // R17 condition high enables
    // R18 condition low uses keep/off
    assign mode_next[i] = !pins_live ? rmvs_pkg::RMVS_MODE_OFF :
                          (!strap_s && !use_pins[i]) ? rmvs_pkg::RMVS_MODE_ON :
                          low_mode(level_hi[i], low_reg.keep_bits[i], low_reg.off_bits[i]);
  end

  // Registered decisions
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mode_reg <= 16'h0000;
      alt_reg  <= 8'h00;
      cond_reg <= 8'h00;
    end else begin
      for (int i = 0; i < NRES; i++) begin
        mode_reg[i*2 +: 2] <= mode_next[i];
      end
      alt_reg  <= alt_next;
      cond_reg <= cond;
    end
  end

  // Read data mux; unmapped offsets read zero
  wire [31:0] rd_mux =
      hit_asg  ? {24'h000000, assign_reg[asg_idx]} :
      hit_vsel ? {16'h0000, vsel_reg} :
      hit_low  ? {16'h0000, low_reg} :
      hit_dev  ? {30'h0, devctl_reg} :
      hit_map  ? {24'h000000, ldomap_reg} :
      (addr == `RMVS_OFF_STATUS0) ? {14'h0, state_reg, cond_reg, alt_reg} :
      (addr == `RMVS_OFF_STATUS1) ? {16'h0000, mode_reg} : 32'h00000000;

  // Read data captured on the wait cycle
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_reg <= 32'h00000000;
    end else if (avs_read && wait_reg) begin
      rdata_reg <= rd_mux;
    end
  end

  // Outputs
  assign avs_readdata      = rdata_reg;
  assign avs_waitrequest   = wait_reg;
  assign resource_mode_out = mode_reg;
  assign alt_select_out    = alt_reg;
  assign device_state_out  = state_reg;

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_pin_sel;
    !strap_s ##0 $stable(en_s[0]);
  endsequence

  property p_strap_low_vsel;
    s_pin_sel |=> alt_reg[0] == $past(en_s[0]);
  endproperty
  a_strap_low_vsel: assert property (p_strap_low_vsel) // R3
    else $error("strap low: buck 0 voltage register does not follow its pin");

  property p_voltage_reg_select_bit_alt;
    strap_s && voltage_reg_select_bit_b[1] |=> alt_reg[1];
  endproperty
  a_voltage_reg_select_bit_alt: assert property (p_voltage_reg_select_bit_alt) // R4
    else $error("select bit set but alternate register not chosen");

  property p_lowvolt;
    strap_s && !voltage_reg_select_bit_b[4] && !level_hi[4] |=> alt_reg[4] == $past(lowv_b[4]);
  endproperty
  a_lowvolt: assert property (p_lowvolt) // R5
    else $error("low level: LDO voltage register ignores low-state bit");

  property p_or_enable;
    use_pins[1] && cond[1] |=> resource_mode_out[3:2] == rmvs_pkg::RMVS_MODE_ON;
  endproperty
  a_or_enable: assert property (p_or_enable) // R17
    else $error("assigned resource with high condition not enabled");

  sequence s_leave_op;
    !operating_in ##1 1'b1;
  endsequence

  property p_pins_ignored;
    s_leave_op |=> resource_mode_out == 16'h0000;
  endproperty
  a_pins_ignored: assert property (p_pins_ignored) // R9
    else $error("resources not off outside ACTIVE and SLEEP");

  property p_sleep_gate;
    (irq_pending_in || !devctl_reg.sleep_en) |=> state_reg != rmvs_pkg::RMVS_ST_SLEEP;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) // R10
    else $error("sleep entered while gated off or interrupt pending");

  property p_unassigned_keep;
    strap_s && !use_pins[5] && state_reg == rmvs_pkg::RMVS_ST_SLEEP && low_reg.keep_bits[5]
      |=> resource_mode_out[11:10] == rmvs_pkg::RMVS_MODE_ON;
  endproperty
  a_unassigned_keep: assert property (p_unassigned_keep) // R13
    else $error("unassigned resource with keep bit not on in sleep");

  property p_unassigned_off;
    strap_s && !use_pins[6] && state_reg == rmvs_pkg::RMVS_ST_SLEEP
      && !low_reg.keep_bits[6] && low_reg.off_bits[6]
      |=> resource_mode_out[13:12] == rmvs_pkg::RMVS_MODE_OFF;
  endproperty
  a_unassigned_off: assert property (p_unassigned_off) // R15
    else $error("unassigned resource with off bit not off in sleep");

  property p_otp_load;
    otp_load_in |=> assign_reg[0] == $past(otp_assign_in[7:0]);
  endproperty
  a_otp_load: assert property (p_otp_load) // R8
    else $error("OTP assignment copy not taken");

  property p_unassigned_eco;
    strap_s && !use_pins[7] && state_reg == rmvs_pkg::RMVS_ST_SLEEP
      && !low_reg.keep_bits[7] && !low_reg.off_bits[7]
      |=> resource_mode_out[15:14] == rmvs_pkg::RMVS_MODE_ECO;
  endproperty
  a_unassigned_eco: assert property (p_unassigned_eco) // R14
    else $error("unassigned resource with both bits clear not eco in sleep");

  property p_assigned_low_off;
    use_pins[1] && !cond[1] && !low_reg.keep_bits[1] && low_reg.off_bits[1]
      |=> resource_mode_out[3:2] == rmvs_pkg::RMVS_MODE_OFF;
  endproperty
  a_assigned_low_off: assert property (p_assigned_low_off) // R18
    else $error("assigned resource with low condition and off bit not off");

  property p_strap_low_free_on;
    !strap_s && pins_live && !(assign_reg[0][5] | assign_reg[1][5] | assign_reg[2][5])
      |=> resource_mode_out[11:10] == rmvs_pkg::RMVS_MODE_ON;
  endproperty
  a_strap_low_free_on: assert property (p_strap_low_free_on) // R19
    else $error("strap low: resource without request pin not on");

  property p_ldo_map_sel;
    !strap_s |=> alt_reg[4] == $past(en_s[ldomap_reg[1:0]]);
  endproperty
  a_ldo_map_sel: assert property (p_ldo_map_sel) // R21
    else $error("strap low: first LDO voltage register ignores its mapped pin");

  property p_sleep_enter;
    operating_in && strap_s && devctl_reg.sleep_en && !irq_pending_in
      && (sleep_s == devctl_reg.sleep_pin_polarity_bit) |=> state_reg == rmvs_pkg::RMVS_ST_SLEEP;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) // R11
    else $error("sleep pin at its active level but sleep not entered");

endmodule : rmvs_top

`default_nettype wire
